// ==== tx_phy_regs.v ====
// Avalon-MM control and status register bank for a four-lane link transmitter PHY
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
`include "tx_phy_regs_consts.vh"

module tx_phy_regs (
  input  wire        clk,
  input  wire        reset,
  input  wire [9:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output wire [31:0] readdata,
  output wire        waitrequest,
  output wire        irq,
  output wire        phy_reset,
  output wire [2:0]  link_rate_code,
  output wire        rate_sel_5g40,
  output wire        rate_sel_2g70,
  output wire        rate_sel_1g62,
  output wire        rate_code_invalid,
  output wire [3:0]  lane_power_down,
  output wire [19:0] pre_tap_level,
  output wire [19:0] post_tap_level,
  input  wire [3:0]  lane_reset_done,
  input  wire        pll_lock_lane01,
  input  wire        pll_lock_lane23,
  input  wire        pll_lock_fabric,
  input  wire [7:0]  lane_buffer_status,
  input  wire [7:0]  lane_tx_error
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge_bytes[k*8 +: 8] = be[k] ? new_val[k*8 +: 8] : old_val[k*8 +: 8];
      end
    end
  endfunction

  function [3:0] rate_decode;
    input [2:0] code;
    begin
      case (code)
        `RATE_5G40: rate_decode = 4'h1;
        `RATE_2G70: rate_decode = 4'h2;
        `RATE_1G62: rate_decode = 4'h4;
        default:    rate_decode = 4'h8;
      endcase
    end
  endfunction

  // One-hot lane match over a block of four per-lane registers; the write
  // decode and the read mux share it so they can never disagree
  function [3:0] lane_hit;
    input [9:0] addr;
    input [9:0] base;
    integer n;
    begin
      for (n = 0; n < `LANES; n = n + 1) begin
        lane_hit[n] = (addr == base + `LANE_STRIDE * n[9:0]);
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Bus access: one wait cycle so read data comes from a flip-flop
  // --------------------------------------------------------------------------
  reg         ack_r;
  reg  [31:0] rdata_r;
  reg  [31:0] rdata_nxt;
  wire        acc      = (read | write) & ~ack_r;
  wire        wr_take  = write & ack_r;

  assign waitrequest = (read | write) & ~ack_r;
  assign readdata    = rdata_r;

  always @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  reg         phy_reset_r;
  reg  [2:0]  rate_r;
  reg  [3:0]  rate_onehot_r;
  reg  [3:0]  power_down_r;
  reg  [4:0]  pre_r  [0:3];
  reg  [4:0]  post_r [0:3];
  reg  [3:0]  irq_status_r;
  reg  [3:0]  irq_mask_r;
  wire [31:0] wval_cfg  = merge_bytes({31'h0000_0000, phy_reset_r}, writedata, byteenable);
  wire [31:0] wval_rate = merge_bytes({29'h0000_0000, rate_r}, writedata, byteenable);
  wire [31:0] wval_pd   = merge_bytes({28'h000_0000, power_down_r}, writedata, byteenable);
  wire [3:0]  pre_hit   = lane_hit(address, `OFS_PRE_LANE0);
  wire [3:0]  post_hit  = lane_hit(address, `OFS_POST_LANE0);

  always @(posedge clk) begin
    if (reset) begin
      phy_reset_r  <= `RST_RESET_CONFIG;
      rate_r       <= `RST_RATE;
      rate_onehot_r <= rate_decode(`RST_RATE);                       // [R1]
      power_down_r <= `RST_POWER_DOWN;
    end else if (wr_take) begin
      if (address == `OFS_RESET_CONFIG) begin
        phy_reset_r <= wval_cfg[`PHY_RESET_BIT];                    // [R13]
      end
      if (address == `OFS_RATE_SELECT) begin
        rate_r        <= wval_rate[2:0];                             // [R1]
        // Decoded alongside the code so the selects come from flip-flops
        rate_onehot_r <= rate_decode(wval_rate[2:0]);                // [R1]
      end
      if (address == `OFS_POWER_DOWN) begin
        power_down_r <= wval_pd[3:0];                                // [R2]
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `LANES; g = g + 1) begin : lane
      wire [31:0] wval_pre  = merge_bytes({27'h000_0000, pre_r[g]}, writedata, byteenable);
      wire [31:0] wval_post = merge_bytes({27'h000_0000, post_r[g]}, writedata, byteenable);
      always @(posedge clk) begin
        if (reset) begin
          pre_r[g]  <= `RST_TAP;
          post_r[g] <= `RST_TAP;
        end else if (wr_take) begin
          if (pre_hit[g]) begin
            pre_r[g] <= wval_pre[4:0];                               // [R3] [R4]
          end
          if (post_hit[g]) begin
            post_r[g] <= wval_post[4:0];                             // [R5] [R6]
          end
        end
      end
      assign pre_tap_level[g*5 +: 5]  = pre_r[g];                    // [R3] [R4]
      assign post_tap_level[g*5 +: 5] = post_r[g];                   // [R5] [R6]
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Live status word
  // --------------------------------------------------------------------------
  // Taken straight from the lane pins; nothing here is stored, so writes cannot reach it
  wire [31:0] state_word;
  assign state_word[3:0]   = lane_reset_done;                        // [R8]
  assign state_word[6:4]   = {pll_lock_fabric, pll_lock_lane23, pll_lock_lane01}; // [R9]
  assign state_word[15:7]  = 9'h000;                                 // [R10]
  generate
    for (g = 0; g < `LANES; g = g + 1) begin : field
      // Buffer status then error per lane; lane 2 error lands at 27:26
      assign state_word[`LANE_FIELD_BASE + g*4 +: 2]     = lane_buffer_status[g*2 +: 2]; // [R11]
      assign state_word[`LANE_FIELD_BASE + g*4 + 2 +: 2] = lane_tx_error[g*2 +: 2];     // [R12] [R15]
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Interrupt events: PLL lock loss and the OR of all lane error bits rising
  // --------------------------------------------------------------------------
  reg  [3:0] ev_prev_r;
  wire [3:0] ev_level = {|lane_tx_error, ~pll_lock_fabric, ~pll_lock_lane23, ~pll_lock_lane01};
  wire [3:0] ev_rise  = ev_level & ~ev_prev_r;
  wire       wr_irqst = wr_take & (address == `OFS_IRQ_STATUS) & byteenable[0];
  wire       wr_irqmk = wr_take & (address == `OFS_IRQ_MASK) & byteenable[0];
  reg        irq_r;
  // A new event in the clearing cycle stays set
  wire [3:0] irq_status_nxt = (irq_status_r & ~(wr_irqst ? writedata[3:0] : 4'h0)) | ev_rise;
  wire [3:0] irq_mask_nxt   = wr_irqmk ? writedata[3:0] : irq_mask_r;

  always @(posedge clk) begin
    if (reset) begin
      ev_prev_r    <= 4'h0;
      irq_status_r <= 4'h0;
      irq_mask_r   <= 4'h0;
      irq_r        <= 1'b0;
    end else begin
      ev_prev_r    <= ev_level;
      irq_status_r <= irq_status_nxt;
      irq_mask_r   <= irq_mask_nxt;
      // Built from the next values so the pin rises with its status bit
      irq_r        <= |(irq_status_nxt & irq_mask_nxt);
    end
  end

  assign irq = irq_r;

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  integer i;
  always @* begin
    rdata_nxt = 32'h0000_0000;                                       // [R14]
    case (address)
      `OFS_RESET_CONFIG: rdata_nxt[0]   = phy_reset_r;
      `OFS_RATE_SELECT:  rdata_nxt[2:0] = rate_r;
      `OFS_POWER_DOWN:   rdata_nxt[3:0] = power_down_r;
      `OFS_STATE:        rdata_nxt      = state_word;                // [R7]
      `OFS_IRQ_STATUS:   rdata_nxt[3:0] = irq_status_r;
      `OFS_IRQ_MASK:     rdata_nxt[3:0] = irq_mask_r;
      default: begin
        for (i = 0; i < `LANES; i = i + 1) begin
          if (pre_hit[i]) begin
            rdata_nxt[4:0] = pre_r[i];
          end
          if (post_hit[i]) begin
            rdata_nxt[4:0] = post_r[i];
          end
        end
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (acc & read) begin
      rdata_r <= rdata_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // PHY-side drives
  // --------------------------------------------------------------------------
  assign phy_reset         = phy_reset_r;                            // [R13]
  assign link_rate_code    = rate_r;
  assign rate_sel_5g40     = rate_onehot_r[0];                       // [R1]
  assign rate_sel_2g70     = rate_onehot_r[1];
  assign rate_sel_1g62     = rate_onehot_r[2];
  assign rate_code_invalid = rate_onehot_r[3];
  assign lane_power_down   = power_down_r;                           // [R2]

endmodule

// ==== tx_phy_regs_consts.vh ====
// Constants for the transmitter PHY control and status register bank
//
// Operation
// R1: Decode 3-bit link rate code 05/03/01 into PLL rate selects 5.40/2.70/1.62.
// R2: Four-bit lane power-down field; a one powers that lane's transceiver down.
// R3: Lane 0 holds a writable 5-bit pre-cursor level driven to its transmitter.
// R4: Lanes 1 to 3 have pre-cursor registers identical to lane 0.
// R5: Lane 0 holds a writable 5-bit post-cursor level driven to its transmitter.
// R6: Lanes 1 to 3 have post-cursor registers identical to lane 0.
// R7: Status register is read-only, showing live transceiver state, not stored writes.
// R8: Status bits 1:0 reset-done lanes 0-1, bits 3:2 lanes 2-3.
// R9: Status bit 4 lane 0/1 PLL lock, bit 5 lane 2/3, bit 6 fabric.
// R10: Status bits 15 through 7 read as zero.
// R11: Per-lane 2-bit buffer then error fields from bit 16 to lane 3 buffer 29:28.
// R12: Lane 2 transmitter error sits in status bits 27:26.
// R13: PHY-reset control bit 0 holds the PHY in reset while set.
// R14: Writes to status are ignored; unimplemented control bits read as zero.
// R15: Lane 1 and lane 3 error fields fill the unlisted 2-bit slots.
`ifndef TX_PHY_REGS_CONSTS_VH
`define TX_PHY_REGS_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_RESET_CONFIG   10'h200
`define OFS_RATE_SELECT    10'h234
`define OFS_POWER_DOWN     10'h238
`define OFS_PRE_LANE0      10'h24C
`define OFS_POST_LANE0     10'h25C
`define OFS_STATE          10'h280
`define OFS_IRQ_STATUS     10'h290
`define OFS_IRQ_MASK       10'h294
`define LANE_STRIDE        10'h004

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define RATE_W             3
`define RATE_5G40          3'h5
`define RATE_2G70          3'h3
`define RATE_1G62          3'h1
`define LANES              4
`define TAP_W              5
`define PHY_RESET_BIT      0
`define LOCK_BASE          4
`define LANE_FIELD_BASE    16
`define IRQ_W              4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_RESET_CONFIG   1'h1
`define RST_RATE           3'h1
`define RST_POWER_DOWN     4'h0
`define RST_TAP            5'h00

`endif

// ==== tx_phy_regs_properties.sv ====
// Concurrent checks on the PHY register bank ports
`timescale 1ns/1ns
module tx_phy_regs_properties (
  input logic        clk,
  input logic        reset,
  input logic [9:0]  address,
  input logic        read,
  input logic        write,
  input logic [31:0] writedata,
  input logic [3:0]  byteenable,
  input logic [31:0] readdata,
  input logic        waitrequest,
  input logic        irq,
  input logic        phy_reset,
  input logic [2:0]  link_rate_code,
  input logic        rate_sel_5g40,
  input logic        rate_sel_2g70,
  input logic        rate_sel_1g62,
  input logic [3:0]  lane_power_down,
  input logic [19:0] pre_tap_level,
  input logic [19:0] post_tap_level
);
// ----------------------------------------------------------------------------
// Bus timing and register effects
// ----------------------------------------------------------------------------
default clocking @(posedge clk); endclocking
default disable iff (reset);
wire wr = write && !waitrequest && byteenable[0];
wire rd = read && !waitrequest;
one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
  else $error("no answer after one wait");
first_wait_a: assert property ($rose(read || write) |-> waitrequest)
  else $error("request not stalled");
idle_wait_a: assert property (!read && !write |-> !waitrequest)
  else $error("wait while idle");
rate_decode_a: assert property (rate_sel_5g40 == (link_rate_code == 3'h5)
  && rate_sel_2g70 == (link_rate_code == 3'h3) && rate_sel_1g62 == (link_rate_code == 3'h1))
  else $error("rate decode wrong");
rate_write_a: assert property (wr && address == 10'h234 |=>
  link_rate_code == $past(writedata[2:0])) else $error("rate");
power_write_a: assert property (wr && address == 10'h238 |=>
  lane_power_down == $past(writedata[3:0])) else $error("pd");
phy_hold_a: assert property (wr && address == 10'h200 |=>
  phy_reset == $past(writedata[0])) else $error("phy reset");
pre_lane0_a: assert property (wr && address == 10'h24C |=>
  pre_tap_level[4:0] == $past(writedata[4:0])) else $error("pre");
post_lane3_a: assert property (wr && address == 10'h268 |=>
  post_tap_level[19:15] == $past(writedata[4:0])) else $error("post");
tap_hold_a: assert property (!write |=>
  $stable(pre_tap_level) && $stable(post_tap_level)) else $error("tap moved");
status_gap_a: assert property (rd && address == 10'h280 |->
  readdata[15:7] == 9'h0) else $error("status gap");
unmapped_a: assert property (rd && address == 10'h3FC |->
  readdata == 32'h0000_0000) else $error("unmapped read");
cover property (wr && address == 10'h234);
cover property ($rose(irq));
cover property (rd && address == 10'h280);
endmodule

// ==== phy_lanes_model.sv ====
// Behavioural model of the four transceiver lanes and their PLLs
`timescale 1ns/1ns
module phy_lanes_model (
  input  logic        clk,
  input  logic        phy_reset,
  input  logic [3:0]  lane_power_down,
  input  logic [2:0]  lock_en,
  input  logic [15:0] noise,
  output logic [3:0]  lane_reset_done = 4'h0,
  output logic        pll_lock_lane01 = 1'b1,
  output logic        pll_lock_lane23 = 1'b1,
  output logic        pll_lock_fabric = 1'b1,
  output logic [7:0]  lane_buffer_status = 8'h00,
  output logic [7:0]  lane_tx_error = 8'h00
);
// ----------------------------------------------------------------------------
// Lane state, one cycle behind the controls
// ----------------------------------------------------------------------------
always @(posedge clk) begin
  // A lane held in reset or powered down never reports done
  lane_reset_done <= phy_reset ? 4'h0 : ~lane_power_down;
  {pll_lock_fabric, pll_lock_lane23, pll_lock_lane01} <= lock_en;
  lane_buffer_status <= noise[7:0];
  lane_tx_error <= noise[15:8];
end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the transmitter PHY register bank
`timescale 1ns/1ns
module tb_top;
// ----------------------------------------------------------------------------
// Signals, model state and helpers
// ----------------------------------------------------------------------------
logic clk = 0, reset = 1, read = 0, write = 0, irq, phy_reset, waitrequest;
logic rate_sel_5g40, rate_sel_2g70, rate_sel_1g62, rate_code_invalid;
logic pll_lock_lane01, pll_lock_lane23, pll_lock_fabric;
logic [9:0] address = 10'h000;
logic [31:0] writedata = 32'h0000_0000, readdata, q;
logic [3:0] byteenable = 4'h0, lane_power_down, lane_reset_done;
logic [2:0] link_rate_code, lock_en = 3'h7;
logic [19:0] pre_tap_level, post_tap_level;
logic [15:0] noise = 16'h0000;
logic [7:0] lane_buffer_status, lane_tx_error;
int failures = 0, compares = 0, m[int], k, a;
bit [31:0] seed = 32'hcc06_99ee;
int regs[$] = '{10'h200, 10'h234, 10'h238, 10'h24C, 10'h250, 10'h254, 10'h258, 10'h25C, 10'h260, 10'h264, 10'h268};
tx_phy_regs tx_phy_regs_i (.*);
phy_lanes_model phy_lanes_model_i (.*);
always #4 clk = ~clk;
function bit [31:0] rnd();
  seed ^= seed << 13;
  seed ^= seed >> 17;
  seed ^= seed << 5;
  return seed;
endfunction
function int msk(int ad);
  return ad == 10'h200 ? 1 : ad == 10'h234 ? 7 : ad == 10'h238 ? 15 : 31;
endfunction
function logic [47:0] outs();
  logic [19:0] pr, po;
  for (int i = 0; i < 4; i++) begin
    pr[5*i+:5] = m[10'h24C + 4*i][4:0];
    po[5*i+:5] = m[10'h25C + 4*i][4:0];
  end
  return {m[10'h200][0], m[10'h234][2:0], m[10'h238][3:0], pr, po};
endfunction
function logic [31:0] st();
  st = {25'h0, lock_en, (m[10'h200][0] ? 4'h0 : ~m[10'h238][3:0])};
  for (int i = 0; i < 4; i++) begin
    st[16+4*i+:2] = noise[2*i+:2];
    st[18+4*i+:2] = noise[8+2*i+:2];
  end
endfunction
task chk(input logic [47:0] s, input logic [47:0] e);
  compares++;
  if (s !== e) begin
    failures++;
    $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
  end
endtask
// Holds the request until waitrequest is sampled low, then takes the answer;
// only the watchdog ends a wait that never finishes
task bus(input bit rd, input logic [9:0] ad, input logic [31:0] d, input logic [3:0] be);
  @(posedge clk);
  read <= rd;
  write <= !rd;
  address <= ad;
  writedata <= d;
  byteenable <= be;
  do begin
    @(posedge clk);
  end while (waitrequest !== 1'b0);
  q = readdata;
  read <= 0;
  write <= 0;
  if (!rd && m.exists(ad) && be[0]) m[ad] = d & msk(ad);
endtask
task conclude();
  if (failures == 0 && compares > 0) $display("Test passed");
  else $display("Test failed");
  $finish;
endtask
// ----------------------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------------------
initial begin
  foreach (regs[i]) m[regs[i]] = 0;
  m[10'h200] = 1;
  m[10'h234] = 1;
  repeat (16) @(posedge clk);
  reset <= 0;
  foreach (regs[i]) begin
    bus(1, regs[i], 0, 4'hF);
    chk(q, m[regs[i]]);
  end
  repeat (60) begin
    a = regs[rnd() % 11];
    bus(0, a, rnd(), 4'(rnd()));
    bus(1, a, 0, 4'hF);
    chk(q, m[a]);
    chk({phy_reset, link_rate_code, lane_power_down, pre_tap_level, post_tap_level}, outs());
  end
  for (k = 0; k < 8; k++) begin
    bus(0, 10'h234, k, 4'h1);
    @(posedge clk);
    chk({rate_sel_5g40, rate_sel_2g70, rate_sel_1g62, rate_code_invalid},
        {k == 5, k == 3, k == 1, k != 5 && k != 3 && k != 1});
  end
  repeat (8) begin
    noise <= 16'(rnd());
    lock_en <= 3'(rnd());
    bus(0, 10'h280, rnd(), 4'hF);
    bus(1, 10'h280, 0, 4'hF);
    chk(q, st());
  end
  bus(0, 10'h3FC, rnd(), 4'hF);
  bus(1, 10'h3FC, 0, 4'hF);
  chk(q, 0);
  // Interrupt on loss of the lane 0/1 PLL lock: raise, mask, clear
  lock_en <= 3'h7;
  noise <= 16'h0000;
  bus(0, 10'h294, 1, 4'hF);
  bus(0, 10'h290, 15, 4'hF);
  @(posedge clk);
  chk(irq, 0);
  lock_en <= 3'h6;
  repeat (3) @(posedge clk);
  chk(irq, 1);
  bus(1, 10'h290, 0, 4'hF);
  chk(q, 1);
  for (k = 0; k < 3; k++) begin
    bus(0, k < 2 ? 10'h294 : 10'h290, k < 1 ? 0 : 1, 4'hF);
    @(posedge clk);
    chk(irq, k == 1);
  end
  conclude();
end
initial begin
  #100000;
  failures++;
  conclude();
end
endmodule
bind tx_phy_regs tx_phy_regs_properties tx_phy_regs_properties_i (.*);
